// ### stack_pkg.sv
// package: offsets, field layout, reset values and states of the sequencer stack entries
package stack_pkg;
   localparam int          ENTRY_W        = 16;
   localparam int          ENTRY_COUNT    = 3;
   localparam int          INDEX_W        = 2;
   localparam int          CHAN_W         = 4;
   localparam int          REGISTER_ADDRESS_FIELD_W      = 6;
   // printed offsets are register indices; byte address is four times the index
   localparam logic [5:0]  IDX_ENTRY_16   = 6'h30;
   localparam logic [5:0]  IDX_ENTRY_17   = 6'h31;
   localparam logic [5:0]  IDX_ENTRY_18   = 6'h32;
   // control and status words at chosen indices
   localparam logic [5:0]  IDX_CONTROL    = 6'h3E;
   localparam logic [5:0]  IDX_STATUS     = 6'h3F;
   // field positions
   localparam int          DIR_BIT        = 15;
   localparam int          REGISTER_ADDRESS_FIELD_MSB    = 14;
   localparam int          REGISTER_ADDRESS_FIELD_LSB    = 9;
   localparam int          RETURN_BIT     = 8;
   localparam int          CHANNEL_SELECT_B_MSB    = 7;
   localparam int          CHANNEL_SELECT_B_LSB    = 4;
   localparam int          CHANNEL_SELECT_A_MSB    = 3;
   localparam int          CHANNEL_SELECT_A_LSB    = 0;
   localparam int          CTRL_RUN_BIT   = 0;
   // reset values
   localparam logic [15:0] RESET_ENTRY_16 = 16'h6000;
   localparam logic [15:0] RESET_ENTRY_17 = 16'h6200;
   localparam logic [15:0] RESET_ENTRY_18 = 16'h6400;
   // ahb encodings
   localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
   localparam logic [1:0]  HTRANS_SEQ     = 2'h3;
   localparam logic [2:0]  HSIZE_WORD     = 3'h2;

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_CONVERT} seq_state_t;
endpackage

// ### entry_if.sv
// interface: bundles current stack entry fields between sequencer and register bank
interface entry_if;
   logic [stack_pkg::INDEX_W-1:0] index;
   logic [stack_pkg::CHAN_W-1:0]  chan_a;
   logic [stack_pkg::CHAN_W-1:0]  chan_b;
   logic                          ret;
   modport bank (input index, output chan_a, output chan_b, output ret);
   modport seq  (output index, input chan_a, input chan_b, input ret);
endinterface

// ### stack_sequencer.sv
// module: steps through the stack entries, one per conversion
module stack_sequencer
(
   // clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic clk_en,
   // control
   input  wire logic run,
   input  wire logic conv_done_sync,
   // entry access
   entry_if.seq      ent,
   // status
   output      logic busy
);
   stack_pkg::seq_state_t         state_q;
   stack_pkg::seq_state_t         state_d;
   logic [stack_pkg::INDEX_W-1:0] idx_q;
   logic [stack_pkg::INDEX_W-1:0] idx_d;
   logic [stack_pkg::INDEX_W-1:0] idx_next;
   logic                          last_entry;

   assign last_entry = (idx_q == stack_pkg::INDEX_W'(stack_pkg::ENTRY_COUNT - 1));
   // return flag or end of the stack goes back to the first entry
   assign idx_next   = (ent.ret || last_entry) ? '0 : idx_q + 2'h1;
   assign ent.index  = idx_q;
   assign busy       = (state_q == stack_pkg::SEQ_CONVERT);

   always_comb
   begin
      state_d = state_q;
      idx_d   = idx_q;
      case (state_q)
         stack_pkg::SEQ_IDLE:
         begin
            idx_d = '0;
            if (run)
               state_d = stack_pkg::SEQ_CONVERT;
         end
         stack_pkg::SEQ_CONVERT:
         begin
            if (!run)
               state_d = stack_pkg::SEQ_IDLE;
            else if (conv_done_sync)
               idx_d = idx_next;
         end
         default:
            state_d = stack_pkg::SEQ_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_q <= stack_pkg::SEQ_IDLE;
         idx_q   <= '0;
      end
      else if (clk_en)
      begin
         state_q <= state_d;
         idx_q   <= idx_d;
      end
   end
endmodule

// ### stack_entries.sv
// module: sequencer stack entries 16 to 18 behind an ahb-lite slave
//
// Local design decision: the AHB-Lite interface to the registers.
module stack_entries
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        clk_en,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output      logic [31:0] hrdata,
   output      logic        hreadyout,
   output      logic        hresp,
   // converter side
   input  wire logic        conv_done,
   output      logic [3:0]  channel_select_a,
   output      logic [3:0]  channel_select_b,
   output      logic        seq_busy
);
   logic [stack_pkg::ENTRY_W-1:0] entry_q [stack_pkg::ENTRY_COUNT];
   logic [stack_pkg::ENTRY_W-1:0] entry_d [stack_pkg::ENTRY_COUNT];
   logic                          run_q;
   logic                          wr_pend_q;
   logic [5:0]                    wr_idx_q;
   logic [31:0]                   hrdata_q;
   logic [3:0]                    chan_a_q;
   logic [3:0]                    chan_b_q;
   logic                          busy_q;
   logic                          done_meta_q;
   logic                          done_sync_q;
   logic                          done_prev_q;
   logic                          done_rise;
   logic                          busy_w;
   logic                          access;
   logic                          rd_access;
   logic                          wr_access;
   logic [5:0]                    addr_idx;
   logic                          wr_ctrl;
   logic [31:0]                   rd_word;
   entry_if                       ent ();

   // index of an entry slot within the array, or all ones when unmapped
   function automatic logic [1:0] slot_of(input logic [5:0] idx);
      case (idx)
         stack_pkg::IDX_ENTRY_16: slot_of = 2'h0;
         stack_pkg::IDX_ENTRY_17: slot_of = 2'h1;
         stack_pkg::IDX_ENTRY_18: slot_of = 2'h2;
         default:                 slot_of = 2'h3;
      endcase
   endfunction

   // reset word of each slot
   function automatic logic [15:0] reset_of(input int slot);
      case (slot)
         0:       reset_of = stack_pkg::RESET_ENTRY_16;
         1:       reset_of = stack_pkg::RESET_ENTRY_17;
         default: reset_of = stack_pkg::RESET_ENTRY_18;
      endcase
   endfunction

   // address phase decode
   assign access    = hsel && hready && (htrans == stack_pkg::HTRANS_NONSEQ
                      || htrans == stack_pkg::HTRANS_SEQ);
   assign rd_access = access && !hwrite;
   assign wr_access = access && hwrite;
   assign addr_idx  = haddr[7:2];
   assign wr_ctrl   = wr_pend_q && (wr_idx_q == stack_pkg::IDX_CONTROL);

   // read mux
   always_comb
   begin
      rd_word = 32'h0000_0000;
      case (addr_idx)
         stack_pkg::IDX_ENTRY_16,
         stack_pkg::IDX_ENTRY_17,
         stack_pkg::IDX_ENTRY_18:
            rd_word = {16'h0000, entry_q[slot_of(addr_idx)]};
         stack_pkg::IDX_CONTROL:
            rd_word = {31'h0000_0000, run_q};
         stack_pkg::IDX_STATUS:
            rd_word = {24'h00_0000, busy_q, 1'b0, 2'(ent.index), chan_b_q};
         default:
            rd_word = 32'h0000_0000;
      endcase
   end

   // write data lands in the data phase
   always_comb
   begin
      for (int i = 0; i < stack_pkg::ENTRY_COUNT; i++)
      begin
         entry_d[i] = entry_q[i];
         if (wr_pend_q && slot_of(wr_idx_q) == 2'(i))
            entry_d[i] = hwdata[15:0];
      end
   end

   // current entry fields for the sequencer
   assign ent.chan_a = entry_q[ent.index][stack_pkg::CHANNEL_SELECT_A_MSB:stack_pkg::CHANNEL_SELECT_A_LSB];
   assign ent.chan_b = entry_q[ent.index][stack_pkg::CHANNEL_SELECT_B_MSB:stack_pkg::CHANNEL_SELECT_B_LSB];
   assign ent.ret    = entry_q[ent.index][stack_pkg::RETURN_BIT];

   // conversion done pin synchroniser and edge detect
   assign done_rise = done_sync_q && !done_prev_q;

   stack_sequencer u_seq
   (
      .hclk           (hclk),
      .hresetn        (hresetn),
      .clk_en         (clk_en),
      .run            (run_q),
      .conv_done_sync (done_rise),
      .ent            (ent.seq),
      .busy           (busy_w)
   );

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int i = 0; i < stack_pkg::ENTRY_COUNT; i++)
            entry_q[i] <= reset_of(i);
      end
      else if (clk_en)
      begin
         for (int i = 0; i < stack_pkg::ENTRY_COUNT; i++)
            entry_q[i] <= entry_d[i];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         wr_idx_q  <= 6'h00;
         hrdata_q  <= 32'h0000_0000;
         run_q     <= 1'b0;
      end
      else if (clk_en)
      begin
         wr_pend_q <= wr_access;
         wr_idx_q  <= addr_idx;
         if (rd_access)
            hrdata_q <= rd_word;
         if (wr_ctrl)
            run_q <= hwdata[stack_pkg::CTRL_RUN_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         done_meta_q <= 1'b0;
         done_sync_q <= 1'b0;
         done_prev_q <= 1'b0;
         chan_a_q    <= 4'h0;
         chan_b_q    <= 4'h0;
         busy_q      <= 1'b0;
      end
      else if (clk_en)
      begin
         done_meta_q <= conv_done;
         done_sync_q <= done_meta_q;
         done_prev_q <= done_sync_q;
         chan_a_q    <= ent.chan_a;
         chan_b_q    <= ent.chan_b;
         busy_q      <= busy_w;
      end
   end

   assign hrdata           = hrdata_q;
   assign hreadyout        = 1'b1;
   assign hresp            = 1'b0;
   assign channel_select_a = chan_a_q;
   assign channel_select_b = chan_b_q;
   assign seq_busy         = busy_q;
endmodule

// ### stack_entries_properties.sv
// checker: port-level properties of the stack entry bank
module stack_entries_properties
(
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // converter
   input wire logic        conv_done,
   input wire logic [3:0]  channel_select_a,
   input wire logic [3:0]  channel_select_b,
   input wire logic        seq_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic       acc;
   logic       ctl;
   logic [3:0] quiet_q;
   assign acc = hsel && htrans[1] && hready;
   assign ctl = acc && hwrite && haddr[7:2] == stack_pkg::IDX_CONTROL;
   // cycles since last bus transfer or done pulse
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn) quiet_q <= 4'h0;
      else if (acc || conv_done) quiet_q <= 4'h0;
      else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
   a_zero_wait: assert property (hreadyout) else $error("wait state");
   a_resp_okay: assert property (!hresp) else $error("error response");
   a_upper_zero: assert property (hrdata[31:16] == 16'h0) else $error("upper data");
   a_reset_clear: assert property ($rose(hresetn) |-> !seq_busy &&
      channel_select_a == 4'h0 && channel_select_b == 4'h0) else $error("reset state");
   a_read_source: assert property ($changed(hrdata) |-> $past(acc && !hwrite))
      else $error("stray read data");
   a_chan_quiet: assert property (quiet_q > 4'h5 |-> $stable(channel_select_a) &&
      $stable(channel_select_b) && $stable(seq_busy)) else $error("selector moved");
   a_run_start: assert property (ctl ##1 hwdata[0] |-> ##[1:3] seq_busy)
      else $error("no start");
   a_run_stop: assert property (ctl ##1 !hwdata[0] |-> ##[1:3] !seq_busy)
      else $error("no stop");
endmodule
bind stack_entries stack_entries_properties chk (.*);

// ### conv_model.sv
// converter model: answers each start with one done pulse
module conv_model
(
   // clock
   input  wire logic hclk,
   // handshake
   input  wire logic start,
   output      logic conv_done
);
   timeunit 1ns;
   timeprecision 1ns;
   int   cnt = 0;
   logic done_q = 1'b0;
   assign conv_done = done_q;
   // random delay, pulse three cycles high
   always @(posedge hclk)
   begin
      if (start) cnt <= 4 + $urandom_range(3);
      else if (cnt > 0) cnt <= cnt - 1;
      done_q <= cnt > 0 && cnt < 4;
   end
endmodule

// ### test_stack_entries.sv
// testbench: register access and sequencing of the stack entries
module test_stack_entries;
   timeunit 1ns;
   timeprecision 1ns;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        start = 1'b0;
   logic        rd_v = 1'b0;
   logic        ch_v = 1'b0;
   logic [31:0] hrdata;
   logic        hready;
   logic        conv_done;
   logic [3:0]  ch_a;
   logic [3:0]  ch_b;
   logic        busy;
   logic [31:0] rd_q[$];
   logic [8:0]  ch_q[$];
   logic [15:0] e[3];
   int          fail_count = 0;
   int          tests_run = 0;
   always #20 hclk = ~hclk;
   conv_model cm (.hclk(hclk), .start(start), .conv_done(conv_done));
   stack_entries dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(stack_pkg::HSIZE_WORD),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(),
      .conv_done(conv_done), .channel_select_a(ch_a), .channel_select_b(ch_b),
      .seq_busy(busy));
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] x, s);
      tests_run++;
      if (s !== x) fail_count++;
      if (s !== x) $display("wrong value %s expected %h seen %h", nm, x, s);
   endtask
   task automatic chk_rd(input logic [31:0] s);
      cmp("read data", rd_q.pop_front(), s);
   endtask
   task automatic chk_ch(input logic [8:0] s);
      cmp("selectors and busy", {23'h0, ch_q.pop_front()}, {23'h0, s});
   endtask
   always @(posedge hclk)
   begin
      if (rd_v && hready) chk_rd(hrdata);
      if (ch_v) chk_ch({busy, ch_b, ch_a});
   end
   task automatic bus(input logic w, logic [7:0] a, logic [31:0] d, x);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= stack_pkg::HTRANS_NONSEQ;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      if (!w) rd_q.push_back(x);
      rd_v <= !w;
      do @(posedge hclk); while (hready !== 1'b1);
      rd_v <= 1'b0;
   endtask
   task automatic seq_chk(input int i);
      ch_q.push_back({1'b1, e[i][7:0]});
      ch_v <= 1'b1;
      @(posedge hclk);
      ch_v <= 1'b0;
   endtask
   task automatic conv(input int i);
      start <= 1'b1;
      @(posedge hclk);
      start <= 1'b0;
      repeat (14) @(posedge hclk);
      seq_chk(i);
   endtask
   initial
   begin
      void'($urandom(32'h34800ADA));
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 3; i++)
         bus(0, 8'hC0 + 8'(4 * i), 0, 32'h6000 + 32'(i) * 32'h200);
      bus(0, 8'hD0, 0, 0);
      for (int i = 0; i < 3; i++)
      begin
         e[i] = 16'($urandom);
         bus(1, 8'hC0 + 8'(4 * i), {16'hFFFF, e[i]}, 0);
         bus(0, 8'hC0 + 8'(4 * i), 0, {16'h0, e[i]});
      end
      for (int i = 0; i < 3; i++)
      begin
         e[i] = {1'b1, 6'h30 + 6'(i), 1'b0, 8'($urandom)};
         bus(1, 8'hC0 + 8'(4 * i), {16'h0, e[i]}, 0);
      end
      bus(1, 8'hF8, 1, 0);
      repeat (6) @(posedge hclk);
      seq_chk(0);
      bus(0, 8'hF8, 0, 1);
      bus(0, 8'hFC, 0, {24'h0, 4'h8, e[0][7:4]});
      conv(1);
      conv(2);
      conv(0);
      bus(1, 8'hF8, 0, 0);
      e[1][8] = 1'b1;
      bus(1, 8'hC4, {16'h0, e[1]}, 0);
      bus(0, 8'hFC, 0, {24'h0, 4'h0, e[0][7:4]});
      bus(1, 8'hF8, 1, 0);
      repeat (6) @(posedge hclk);
      seq_chk(0);
      conv(1);
      conv(0);
      summarize();
   end
   initial
   begin
      repeat (2000) @(posedge hclk);
      fail_count++;
      summarize();
   end
endmodule
